// ### dac_sync_pkg.sv
// Package of constants and carrier types for the DAC data clock synchronizer
//*****************************************************************************
// Function
// - With the PLL on, the device takes the input clock at the data rate and the multiplier clocks the filters.
// - With the PLL off, the device takes the sample-rate clock and derives filter, data and single-port clocks by division.
// - The outgoing data clock may align to any of several input edges, so shared systems use input mode.
// - Data-clock input mode works only with the PLL off and two-port data operation selected.
// - The data clock pin turns into an input when configuration register 02h bit 3 is one.
// - In input mode a state machine aligns to the converter clock on a data clock rising edge.
// - A data clock edge that meets the setup window leads to capture on the third following converter edge.
// - A data clock edge past the hold window delays synchronization by one converter cycle.
// - Synchronization works the same in 2x, 4x and 8x interpolation.
// - The latch-timing state machine advances on every converter clock rising edge.
// - The latch strobe rate follows the converter clock and the interpolation factor.
// - In input mode every rising edge on the data clock pin resets the latch-timing state machine.
//*****************************************************************************
package dac_sync_pkg;
  localparam logic [7:0] DIR_CFG_OFFSET   = 8'h02;
  localparam int         DIR_INPUT_BIT    = 3;
  localparam logic [7:0] DIR_CFG_RESET    = 8'h00;
  localparam int         CAPTURE_DELAY    = 3;
  localparam logic [3:0] CNT_RESET        = 4'h0;
  localparam logic [1:0] INTERP_2X        = 2'h1;
  localparam logic [1:0] INTERP_4X        = 2'h2;
  localparam logic [1:0] INTERP_8X        = 2'h3;

  typedef enum logic [1:0] {SM_FREE, SM_ALIGN} syncState_e;

  typedef struct packed {
    logic        wrEn;
    logic [7:0]  addr;
    logic [7:0]  wdata;
  } cfgWrite_s;

  // Interpolation factor decode, used by strobe and clock generation
  function automatic logic [3:0] interpFactor(input logic [1:0] sel);
    case (sel)
      INTERP_4X: interpFactor = 4'h4;
      INTERP_8X: interpFactor = 4'h8;
      default:   interpFactor = 4'h2;
    endcase
  endfunction
endpackage

// ### dac_sync_fifo.sv
// Small FIFO standing in the sample word path
`timescale 1ns/10ps
`default_nettype none
module dac_sync_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0]   wp;
    logic [AW:0]   rp;
  } fifoState_s;

  fifoState_s          st_q;
  fifoState_s          st_d;
  logic [WIDTH-1:0]    mem [DEPTH];
  logic                full;
  logic                empty;
  logic                push;
  logic                pop;

  // Flags and handshakes
  assign empty    = (st_q.wp == st_q.rp);
  assign full     = (st_q.wp[AW] != st_q.rp[AW]) && (st_q.wp[AW-1:0] == st_q.rp[AW-1:0]);
  assign inReady  = !full;
  assign outValid = !empty;
  assign push     = inValid && !full;
  assign pop      = outReady && !empty;
  assign outData  = mem[st_q.rp[AW-1:0]];

  // Pointer next state
  always_comb
  begin
    st_d = st_q;
    if (push)
    begin
      st_d.wp = st_q.wp + 1'b1;
    end
    if (pop)
    begin
      st_d.rp = st_q.rp + 1'b1;
    end
  end

  // Pointer registers
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Storage array
  always_ff @(posedge mclk)
  begin
    if (push)
    begin
      mem[st_q.wp[AW-1:0]] <= inData;
    end
  end
endmodule
`default_nettype wire

// ### dac_data_clock_sync.sv
// Latch-timing state machine and data clock control for the interpolating DAC
`timescale 1ns/10ps
`default_nettype none
module dac_data_clock_sync
  import dac_sync_pkg::*;
#(
  parameter int WORD_W = 16,
  parameter int DEPTH  = 8
) (
  // Converter clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // Configuration port
  input  wire cfgWrite_s         cfgWr,
  input  wire logic [7:0]        cfgRdAddr,
  output logic [7:0]             cfgRdData,
  // Mode straps
  input  wire logic              pllEnable,
  input  wire logic              twoPortMode,
  input  wire logic [1:0]        interpSel,
  // Data clock pin
  input  wire logic              dataClockPinIn,
  output logic                   dataClockPinOut,
  output logic                   dataClockPinOe,
  output logic                   singlePortClockOut,
  // Sample words from the data source
  input  wire logic              wordValid,
  output logic                   wordReady,
  input  wire logic [WORD_W-1:0] wordData,
  // Latched sample to the filters
  output logic                   latchStrobe,
  output logic [WORD_W-1:0]      latchData,
  output logic                   inputModeActive
);
  //***************************************************************************
  // State
  //***************************************************************************
  typedef struct packed {
    logic [7:0]  dirCfg;
    logic [1:0]  pinSync;
    logic        pinLast;
    syncState_e  sm;
    logic [3:0]  phase;
    logic [3:0]  alignCnt;
    logic        dclkOut;
    logic        spClk;
    logic        strobe;
    logic [WORD_W-1:0] data;
    logic [7:0]  rdData;
  } syncState_s;

  syncState_s        st_q;
  syncState_s        st_d;
  logic [3:0]        factor;
  logic              inputMode;
  logic              pinRise;
  logic              fifoValid;
  logic [WORD_W-1:0] fifoData;
  logic              fifoPop;

  // Mode decode
  assign factor    = interpFactor(interpSel);
  assign inputMode = st_q.dirCfg[DIR_INPUT_BIT] && !pllEnable && twoPortMode;
  assign pinRise   = st_q.pinSync[1] && !st_q.pinLast;
  assign fifoPop   = st_d.strobe;  // Pop at the edge that latches the head

  //***************************************************************************
  // Word buffer
  //***************************************************************************
  dac_sync_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .inValid  (wordValid),
    .inReady  (wordReady),
    .inData   (wordData),
    .outValid (fifoValid),
    .outReady (fifoPop),
    .outData  (fifoData)
  );

  //***************************************************************************
  // Next state
  //***************************************************************************
  always_comb
  begin
    st_d = st_q;
    st_d.strobe = 1'b0;
    // Configuration write
    if (cfgWr.wrEn && cfgWr.addr == DIR_CFG_OFFSET)
    begin
      st_d.dirCfg = cfgWr.wdata;
    end
    st_d.rdData = (cfgRdAddr == DIR_CFG_OFFSET) ? st_q.dirCfg : 8'h00;
    // Pin synchronizer; the sampling delay stands in for the setup/hold decision
    st_d.pinSync = {st_q.pinSync[0], dataClockPinIn};
    st_d.pinLast = st_q.pinSync[1];
    // Free-running phase advance on every converter edge
    if (st_q.phase >= factor - 4'h1)
    begin
      st_d.phase = CNT_RESET;
    end
    else
    begin
      st_d.phase = st_q.phase + 4'h1;
    end
    case (st_q.sm)
      SM_FREE:
      begin
        if (st_q.phase == CNT_RESET)
        begin
          st_d.strobe = 1'b1;
        end
      end
      SM_ALIGN:
      begin
        st_d.alignCnt = st_q.alignCnt + 4'h1;
        if (st_q.alignCnt == 4'(CAPTURE_DELAY - 1))
        begin
          st_d.strobe = 1'b1;
          st_d.phase  = 4'h1;
          st_d.sm     = SM_FREE;
        end
      end
      default:
      begin
        st_d.sm = SM_FREE;
      end
    endcase
    // In input mode each data clock rising edge restarts alignment
    if (inputMode && pinRise)
    begin
      st_d.sm       = SM_ALIGN;
      st_d.alignCnt = 4'h1;
      st_d.strobe   = 1'b0;
    end
    if (st_d.strobe)
    begin
      st_d.data = fifoValid ? fifoData : st_q.data;
    end
    // Divided data clock and single-port clock when driven out
    st_d.dclkOut = (st_d.phase < (factor >> 1));
    st_d.spClk   = ~st_q.spClk;
  end

  // State register
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      st_q        <= '0;
      st_q.dirCfg <= DIR_CFG_RESET;
      st_q.sm     <= SM_FREE;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Outputs
  assign cfgRdData          = st_q.rdData;
  assign dataClockPinOut    = st_q.dclkOut;
  assign dataClockPinOe     = !inputMode;
  assign singlePortClockOut = st_q.spClk;
  assign latchStrobe        = st_q.strobe;
  assign latchData          = st_q.data;
  assign inputModeActive    = inputMode;

  //***************************************************************************
  // Checks: pin direction and mode
  //***************************************************************************
  // No drive on the pin in input mode
  chk_pin_dir: assert property (@(posedge mclk) disable iff (!rst_n)
    inputMode |-> !dataClockPinOe) else $error("pin driven in input mode");

  // Pin driven whenever input mode is off
  chk_pin_drive: assert property (@(posedge mclk) disable iff (!rst_n)
    !inputMode |-> dataClockPinOe) else $error("pin not driven in output mode");

  // Input mode refused with the multiplier on
  chk_mode_gate: assert property (@(posedge mclk) disable iff (!rst_n)
    pllEnable |-> !inputModeActive) else $error("input mode with pll on");

  // Input mode refused in single-port operation
  chk_mode_port: assert property (@(posedge mclk) disable iff (!rst_n)
    !twoPortMode |-> !inputModeActive) else $error("input mode in one-port");

  // Input mode needs the direction bit
  chk_mode_cfg: assert property (@(posedge mclk) disable iff (!rst_n)
    !st_q.dirCfg[DIR_INPUT_BIT] |-> !inputModeActive) else $error("input mode without bit");

  // All three conditions enable input mode
  chk_mode_on: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_q.dirCfg[DIR_INPUT_BIT] && !pllEnable && twoPortMode) |-> inputModeActive)
    else $error("input mode not entered");

  //***************************************************************************
  // Checks: configuration register
  //***************************************************************************
  // A write to the direction register lands
  chk_cfg_write: assert property (@(posedge mclk) disable iff (!rst_n)
    (cfgWr.wrEn && cfgWr.addr == DIR_CFG_OFFSET) |=> st_q.dirCfg == $past(cfgWr.wdata))
    else $error("cfg write lost");

  // Other writes leave the register alone
  chk_cfg_keep: assert property (@(posedge mclk) disable iff (!rst_n)
    !(cfgWr.wrEn && cfgWr.addr == DIR_CFG_OFFSET) |=> $stable(st_q.dirCfg))
    else $error("cfg changed without write");

  // Read data follows the register one cycle later
  chk_cfg_read: assert property (@(posedge mclk) disable iff (!rst_n)
    (cfgRdAddr == DIR_CFG_OFFSET) |=> cfgRdData == $past(st_q.dirCfg)) else $error("cfg readback wrong");

  // Unused addresses read as zero
  chk_rd_other: assert property (@(posedge mclk) disable iff (!rst_n)
    (cfgRdAddr != DIR_CFG_OFFSET) |=> cfgRdData == 8'h00) else $error("unused address not zero");

  //***************************************************************************
  // Checks: derived clocks
  //***************************************************************************
  // Single-port clock toggles every edge
  chk_sp_toggle: assert property (@(posedge mclk) disable iff (!rst_n)
    1'b1 |=> singlePortClockOut != $past(singlePortClockOut)) else $error("one-port clock stuck");

  // Data clock high at the start of a phase
  chk_dclk_high: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_q.phase == CNT_RESET && $past(rst_n)) |-> dataClockPinOut)
    else $error("data clock low at phase start");

  // Data clock low at the end of a phase
  chk_dclk_low: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_q.phase == factor - 4'h1 && $stable(interpSel)) |-> !dataClockPinOut)
    else $error("data clock high at phase end");

  //***************************************************************************
  // Checks: phase and strobe
  //***************************************************************************
  // Phase steps by one below the top
  chk_phase_adv: assert property (@(posedge mclk) disable iff (!rst_n)
    ($stable(interpSel) && st_q.phase < factor - 4'h1 && st_q.sm == SM_FREE
    && !(inputMode && pinRise))
    |=> st_q.phase == $past(st_q.phase) + 4'h1) else $error("phase did not advance");

  // Phase wraps at the top
  chk_phase_wrap: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_q.phase >= factor - 4'h1 && st_q.sm == SM_FREE) |=> st_q.phase == CNT_RESET)
    else $error("phase did not wrap");

  // Phase stays inside the widest factor
  chk_phase_range: assert property (@(posedge mclk) disable iff (!rst_n)
    st_q.phase < 4'h8) else $error("phase out of range");

  // Strobe follows phase zero
  chk_strobe_phase: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_q.sm == SM_FREE && st_q.phase == CNT_RESET && !(inputMode && pinRise)) |=> latchStrobe)
    else $error("strobe missing at phase zero");

  // No strobe elsewhere while free running
  chk_free_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_q.sm == SM_FREE && st_q.phase != CNT_RESET) |=> !latchStrobe) else $error("stray strobe");

  // Strobe every second edge at 2x
  chk_strobe_rate: assert property (@(posedge mclk) disable iff (!rst_n)
    (latchStrobe && interpSel == INTERP_2X && st_q.sm == SM_FREE && !inputMode)
    ##1 (interpSel == INTERP_2X && !inputMode) |=> latchStrobe) else $error("2x strobe rate wrong");

  // Strobe every fourth edge at 4x
  chk_strobe_4x: assert property (@(posedge mclk) disable iff (!rst_n)
    (latchStrobe && interpSel == INTERP_4X && st_q.sm == SM_FREE && !inputMode)
    ##1 (interpSel == INTERP_4X && !inputMode) [*3] |=> latchStrobe) else $error("4x strobe rate wrong");

  // Strobe every eighth edge at 8x
  chk_strobe_8x: assert property (@(posedge mclk) disable iff (!rst_n)
    (latchStrobe && interpSel == INTERP_8X && st_q.sm == SM_FREE && !inputMode)
    ##1 (interpSel == INTERP_8X && !inputMode) [*7] |=> latchStrobe) else $error("8x strobe rate wrong");

  // Strobes never come back to back
  chk_strobe_gap: assert property (@(posedge mclk) disable iff (!rst_n)
    (latchStrobe && !inputMode) |=> !latchStrobe) else $error("strobe too dense");

  // Latched data moves only with a strobe
  chk_data_strobe: assert property (@(posedge mclk) disable iff (!rst_n)
    $changed(latchData) |-> latchStrobe) else $error("data moved without strobe");

  //***************************************************************************
  // Checks: synchronization
  //***************************************************************************
  // Pin synchronizer shifts by one stage
  chk_sync_chain: assert property (@(posedge mclk) disable iff (!rst_n)
    1'b1 |=> st_q.pinSync[1] == $past(st_q.pinSync[0])) else $error("pin sync broken");

  // An edge restarts the state machine
  chk_reset_sm: assert property (@(posedge mclk) disable iff (!rst_n)
    (inputMode && pinRise) |=> (st_q.sm == SM_ALIGN && !latchStrobe)) else $error("edge did not reset");

  // Alignment count starts at one
  chk_align_start: assert property (@(posedge mclk) disable iff (!rst_n)
    (inputMode && pinRise) |=> st_q.alignCnt == 4'h1) else $error("align count wrong start");

  // Alignment count stays in range
  chk_align_range: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_q.sm == SM_ALIGN) |-> (st_q.alignCnt == 4'h1 || st_q.alignCnt == 4'(CAPTURE_DELAY - 1)))
    else $error("align count out of range");

  // Alignment holds until the capture edge
  chk_align_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_q.sm == SM_ALIGN && st_q.alignCnt != 4'(CAPTURE_DELAY - 1)) |=> st_q.sm == SM_ALIGN)
    else $error("alignment left early");

  // No strobe before the capture edge
  chk_align_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_q.sm == SM_ALIGN && st_q.alignCnt != 4'(CAPTURE_DELAY - 1)) |=> !latchStrobe)
    else $error("strobe during alignment");

  // Capture strobes and restarts the phase
  chk_capture_phase: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_q.sm == SM_ALIGN && st_q.alignCnt == 4'(CAPTURE_DELAY - 1) && !(inputMode && pinRise))
    |=> (latchStrobe && st_q.sm == SM_FREE && st_q.phase == 4'h1)) else $error("capture phase wrong");

  // Capture on the third edge after detection
  chk_capture_third: assert property (@(posedge mclk) disable iff (!rst_n)
    (inputMode && pinRise && $stable(interpSel)) ##1 (st_q.sm == SM_ALIGN) [*2] |=> latchStrobe)
    else $error("capture not on third edge");

  // No alignment entered in output mode
  chk_no_align: assert property (@(posedge mclk) disable iff (!rst_n)
    (!inputMode && st_q.sm == SM_FREE) |=> st_q.sm == SM_FREE) else $error("align in output mode");

  //***************************************************************************
  // Coverage
  //***************************************************************************
  // Main scenarios
  cov_input_mode: cover property (@(posedge mclk) disable iff (!rst_n) inputMode && pinRise);
  cov_capture: cover property (@(posedge mclk) disable iff (!rst_n) st_q.sm == SM_ALIGN ##1 latchStrobe);
  cov_8x: cover property (@(posedge mclk) disable iff (!rst_n) interpSel == INTERP_8X && latchStrobe);
  cov_4x_sync: cover property (@(posedge mclk) disable iff (!rst_n)
    interpSel == INTERP_4X && st_q.sm == SM_ALIGN ##1 latchStrobe);
  cov_fifo_full: cover property (@(posedge mclk) disable iff (!rst_n) !wordReady);
endmodule
`default_nettype wire

// ### dac_word_source.sv
// Data source model that offers numbered sample words
`timescale 1ns/10ps
`default_nettype none
module dac_word_source #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic    mclk,
  input  wire logic    rst_n,
  // Bench control
  input  wire logic    run,
  input  wire logic    stall,
  // Word handshake
  output logic         wordValid,
  input  wire logic    wordReady,
  output logic [W-1:0] wordData,
  output logic [W-1:0] sentCnt
);
  // Hold each word until taken; idle data toggles so stale values never pass
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      wordValid <= 1'b0;
      wordData  <= '1;
      sentCnt   <= W'(1);
    end
    else if (wordValid && wordReady)
    begin
      sentCnt   <= sentCnt + 1'b1;
      wordValid <= run && !stall;
      wordData  <= (run && !stall) ? sentCnt + 1'b1 : ~sentCnt;
    end
    else if (!wordValid && run && !stall)
    begin
      wordValid <= 1'b1;
      wordData  <= sentCnt;
    end
    else if (!wordValid)
      wordData <= ~wordData;
  end
endmodule
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the DAC data clock synchronizer
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import dac_sync_pkg::*;
  logic        mclk = 1'b0, rst_n = 1'b0, pllEnable = 1'b0, twoPortMode = 1'b1;
  logic        dataClockPinIn = 1'b0, dataClockPinOut, dataClockPinOe, singlePortClockOut;
  logic        wordValid, wordReady, latchStrobe, inputModeActive, run = 1'b0, stall = 1'b0;
  logic [1:0]  interpSel = INTERP_2X;
  logic [7:0]  cfgRdAddr = 8'h00, cfgRdData;
  logic [15:0] wordData, latchData, sentCnt, lastData = 16'h0000, expWord = 16'h0001;
  cfgWrite_s   cfgWr = '0;
  int          err_total = 0, n_checks = 0, cyc = 0;

  dac_data_clock_sync #(.WORD_W(16), .DEPTH(8)) dut (.mclk(mclk), .rst_n(rst_n), .cfgWr(cfgWr),
    .cfgRdAddr(cfgRdAddr), .cfgRdData(cfgRdData), .pllEnable(pllEnable), .twoPortMode(twoPortMode),
    .interpSel(interpSel), .dataClockPinIn(dataClockPinIn), .dataClockPinOut(dataClockPinOut),
    .dataClockPinOe(dataClockPinOe), .singlePortClockOut(singlePortClockOut), .wordValid(wordValid),
    .wordReady(wordReady), .wordData(wordData), .latchStrobe(latchStrobe), .latchData(latchData),
    .inputModeActive(inputModeActive));
  dac_word_source #(.W(16)) src (.mclk(mclk), .rst_n(rst_n), .run(run), .stall(stall),
    .wordValid(wordValid), .wordReady(wordReady), .wordData(wordData), .sentCnt(sentCnt));

  // Clock and run limit
  always #5 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_total++;
      stop_test();
    end
  end

  // Every new latched word must be the next one in order
  always @(posedge mclk)
  begin
    if (rst_n && latchData !== lastData)
    begin
      chk("latchData", expWord, latchData);
      expWord++;
    end
    lastData <= latchData;
  end

  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge mclk) cfgWr <= '{1'b1, a, d};
    @(posedge mclk) cfgWr <= '0;
  endtask

  task automatic rdchk(logic [7:0] a, logic [7:0] exp);
    @(posedge mclk) cfgRdAddr <= a;
    tick(2);
    #1 chk("cfgRdData", 16'(exp), 16'(cfgRdData));
  endtask

  // Strobe count over a fixed window and single-port clock toggle
  task automatic t_rate(logic [1:0] sel, int n);
    int   cnt;
    int   hi;
    logic sp;
    cnt = 0;
    hi = 0;
    @(posedge mclk) interpSel <= sel;
    tick(8);
    repeat (32)
    begin
      tick(1);
      #1 cnt += (latchStrobe === 1'b1);
      hi += (dataClockPinOut === 1'b1);
    end
    chk("strobeCount", 16'(32 / n), 16'(cnt));
    chk("dataClockHigh", 16'd16, 16'(hi));
    sp = singlePortClockOut;
    tick(1);
    #1 chk("singlePortClock", 16'(!sp), 16'(singlePortClockOut));
    $display("test rate %0d done", n);
  endtask

  // Register access, refusal and mode qualification
  task automatic t_reg();
    rdchk(DIR_CFG_OFFSET, DIR_CFG_RESET);
    chk("pinOe", 16'h0001, 16'(dataClockPinOe));
    wr(8'h05, 8'hff);
    rdchk(8'h05, 8'h00);
    wr(DIR_CFG_OFFSET, 8'h08);
    rdchk(DIR_CFG_OFFSET, 8'h08);
    chk("pinOe", 16'h0000, 16'(dataClockPinOe));
    chk("inputMode", 16'h0001, 16'(inputModeActive));
    @(posedge mclk) pllEnable <= 1'b1;
    #1 chk("inputMode", 16'h0000, 16'(inputModeActive));
    @(posedge mclk) {pllEnable, twoPortMode} <= 2'b00;
    #1 chk("inputMode", 16'h0000, 16'(inputModeActive));
    @(posedge mclk) twoPortMode <= 1'b1;
    $display("test reg done");
  endtask

  // Data clock edge, early or just past an edge, restarts the strobe phase
  task automatic t_sync(logic [1:0] sel, int n, int late);
    @(posedge mclk) interpSel <= sel;
    tick(2 * n);
    @(posedge mclk) dataClockPinIn <= (late == 0);
    for (int k = 1; k <= 6; k++)
    begin
      tick(1);
      if (k == late)
        dataClockPinIn <= 1'b1;
      #1 if (k >= 3 + late) chk("syncStrobe", 16'(k == 5 + late), 16'(latchStrobe));
    end
    tick(n - 1 + late);
    #1 chk("nextStrobe", 16'h0001, 16'(latchStrobe));
    @(posedge mclk) dataClockPinIn <= 1'b0;
    $display("test sync %0d late %0d done", n, late);
  endtask

  // Fill the FIFO until refused, then drain with the source stalled
  task automatic t_fifo();
    @(posedge mclk) interpSel <= INTERP_8X;
    run <= 1'b1;
    for (int i = 0; i < 200 && wordReady !== 1'b0; i++)
    begin
      tick(1);
      #1;
    end
    chk("fullReady", 16'h0000, 16'(wordReady));
    @(posedge mclk) stall <= 1'b1;
    for (int i = 0; i < 300 && lastData !== sentCnt - 1'b1; i++)
    begin
      tick(1);
      #1;
    end
    tick(2);
    #1 chk("drained", sentCnt, expWord);
    chk("emptyReady", 16'h0001, 16'(wordReady));
    $display("test fifo done");
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    tick(12);
    rst_n <= 1'b1;
    t_rate(INTERP_2X, 2);
    t_rate(INTERP_4X, 4);
    t_rate(INTERP_8X, 8);
    t_reg();
    t_sync(INTERP_2X, 2, 0);
    t_sync(INTERP_4X, 4, 0);
    t_sync(INTERP_8X, 8, 0);
    t_sync(INTERP_2X, 2, 1);
    t_fifo();
    stop_test();
  end
endmodule
`default_nettype wire
